/* File: interval_counter_modes.sv */
// one 16-bit down counting channel of an interval timer, modes 0 to 5
// assumes cpu write strobes are one-cycle pulses on i_clk
`timescale 1ns/1ps
`include "interval_counter_cfg.svh"
module interval_counter_modes #(
    parameter logic [1:0] CHANNEL = 2'h0
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // cpu write path
    input wire logic i_ctrl_wr,
    input wire logic i_count_wr,
    input wire logic [`DATA_W-1:0] i_data,
    // channel pins
    input wire logic i_count_clk_pin,
    input wire logic i_gate_trigger_pin,
    // channel results
    output logic o_wave_output_pin,
    output logic [`CNT_W-1:0] o_count_value
);
    pin_events_if ev ();

    pin_conditioner u_pins (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_count_clk_pin(i_count_clk_pin),
        .i_gate_trigger_pin(i_gate_trigger_pin),
        .ev(ev)
    );

    interval_counter_pkg::mode_t operating_mode_field;
    interval_counter_pkg::mode_t next_operating_mode_field;
    logic bcd, next_bcd;
    logic [1:0] byte_access_format, next_byte_access_format;
    logic [`CNT_W-1:0] count_holding_register, next_count_holding_register;
    logic [`CNT_W-1:0] ce, next_ce;
    logic out, next_out;
    logic pending, next_pending;
    logic count_valid, next_count_valid;
    logic running, next_running;
    logic hold, next_hold;
    logic msb_next, next_msb_next;
    logic trig, next_trig;
    logic odd, next_odd;
    logic trig_now, count_done;
    logic [`CNT_W-1:0] ce_dec1, ce_dec2, even_reload, sq_term;

    // three-bit mode field to one-hot mode
    function automatic interval_counter_pkg::mode_t decode_mode(
        input logic [2:0] field
    );
        interval_counter_pkg::mode_t m;
        if (field[1]) begin
            m = field[0] ? interval_counter_pkg::MODE3 :
                interval_counter_pkg::MODE2;
        end else begin
            unique case ({field[2], field[0]})
                2'h0: m = interval_counter_pkg::MODE0;
                2'h1: m = interval_counter_pkg::MODE1;
                2'h2: m = interval_counter_pkg::MODE4;
                default: m = interval_counter_pkg::MODE5;
            endcase
        end
        return m;
    endfunction : decode_mode

    // down count by one or two, binary or four decimal digits
    function automatic logic [`CNT_W-1:0] count_down(
        input logic [`CNT_W-1:0] v,
        input logic dec_mode,
        input logic [1:0] step
    );
        logic [`CNT_W-1:0] r;
        logic [4:0] dig, sub;
        logic borrow;
        r = v;
        borrow = 1'b0;
        if (!dec_mode) begin
            r = v - {14'h0000, step};
        end else begin
            for (int i = 0; i < `BCD_DIGITS; i++) begin
                dig = {1'b0, v[4*i +: 4]};
                sub = {4'h0, borrow};
                if (i == 0) begin
                    sub = sub + {3'h0, step};
                end
                if (dig < sub) begin
                    dig = dig + `BCD_BASE - sub;
                    borrow = 1'b1;
                end else begin
                    dig = dig - sub;
                    borrow = 1'b0;
                end
                r[4*i +: 4] = dig[3:0];
            end
        end
        return r;
    endfunction : count_down

    assign ce_dec1 = count_down(ce, bcd, `STEP_ONE);
    assign ce_dec2 = count_down(ce, bcd, `STEP_TWO);
    assign even_reload = count_holding_register & `RELOAD_EVEN_MASK;
    assign count_done = (ce == `COUNT_ONE);
    // odd count: high half ends at 0, low half at 2
    assign sq_term = (odd && out) ? `COUNT_RESET : `COUNT_TWO;
    assign trig_now = trig | ev.gate_rise;

    always_comb begin
        next_operating_mode_field = operating_mode_field;
        next_bcd = bcd;
        next_byte_access_format = byte_access_format;
        next_count_holding_register = count_holding_register;
        next_ce = ce;
        next_out = out;
        next_pending = pending;
        next_count_valid = count_valid;
        next_running = running;
        next_hold = hold;
        next_msb_next = msb_next;
        next_odd = odd;
        // a rise seen in the tick cycle is used by that tick
        next_trig = ev.tick ? 1'b0 : trig_now;

        if (ev.tick) begin
            unique case (operating_mode_field)
                interval_counter_pkg::MODE0: begin
                    if (pending) begin
                        next_ce = count_holding_register;
                        next_pending = 1'b0;
                        next_running = 1'b1;
                    end else if (running && ev.gate && !hold) begin
                        next_ce = ce_dec1;
                        if (count_done) begin
                            next_out = 1'b1;
                        end
                    end
                end
                interval_counter_pkg::MODE1: begin
                    if (count_valid && trig_now) begin
                        next_ce = count_holding_register;
                        next_out = 1'b0;
                        next_running = 1'b1;
                        next_pending = 1'b0;
                    end else if (running) begin
                        next_ce = ce_dec1;
                        if (count_done) begin
                            next_out = 1'b1;
                            next_running = 1'b0;
                        end
                    end
                end
                interval_counter_pkg::MODE2: begin
                    if (count_valid && (trig_now || (pending && !running))) begin
                        next_ce = count_holding_register;
                        next_out = 1'b1;
                        next_running = 1'b1;
                        next_pending = 1'b0;
                    end else if (running && ev.gate) begin
                        if (count_done) begin
                            next_ce = count_holding_register;
                            next_out = 1'b1;
                            next_pending = 1'b0;
                        end else begin
                            next_ce = ce_dec1;
                            if (ce == `COUNT_TWO) begin
                                next_out = 1'b0;
                            end
                        end
                    end
                end
                interval_counter_pkg::MODE3: begin
                    if (count_valid && (trig_now || (pending && !running))) begin
                        next_ce = even_reload;
                        next_odd = count_holding_register[0];
                        next_out = 1'b1;
                        next_running = 1'b1;
                        next_pending = 1'b0;
                    end else if (running && ev.gate) begin
                        if (ce == sq_term) begin
                            next_out = ~out;
                            next_ce = even_reload;
                            next_odd = count_holding_register[0];
                            next_pending = 1'b0;
                        end else begin
                            next_ce = ce_dec2;
                        end
                    end
                end
                interval_counter_pkg::MODE4: begin
                    if (pending) begin
                        next_ce = count_holding_register;
                        next_out = 1'b1;
                        next_running = 1'b1;
                        next_pending = 1'b0;
                    end else if (!out) begin
                        next_out = 1'b1;
                    end else if (running && ev.gate) begin
                        next_ce = ce_dec1;
                        if (count_done) begin
                            next_out = 1'b0;
                            next_running = 1'b0;
                        end
                    end
                end
                interval_counter_pkg::MODE5: begin
                    if (count_valid && trig_now) begin
                        next_ce = count_holding_register;
                        next_out = 1'b1;
                        next_running = 1'b1;
                        next_pending = 1'b0;
                    end else if (!out) begin
                        next_out = 1'b1;
                    end else if (running) begin
                        next_ce = ce_dec1;
                        if (count_done) begin
                            next_out = 1'b0;
                            next_running = 1'b0;
                        end
                    end
                end
            endcase
        end

        // gate low in the periodic modes holds output high
        if (!ev.gate && (operating_mode_field == interval_counter_pkg::MODE2 ||
                operating_mode_field == interval_counter_pkg::MODE3)) begin
            next_out = 1'b1;
        end

        if (i_ctrl_wr && i_data[`CW_SEL_HI:`CW_SEL_LO] == CHANNEL &&
                i_data[`CW_RL_HI:`CW_RL_LO] != `RL_LATCH) begin
            next_operating_mode_field =
                decode_mode(i_data[`CW_MODE_HI:`CW_MODE_LO]);
            next_bcd = i_data[`CW_BCD_BIT];
            next_byte_access_format = i_data[`CW_RL_HI:`CW_RL_LO];
            next_ce = `COUNT_RESET;
            next_out = (next_operating_mode_field !=
                interval_counter_pkg::MODE0);
            next_pending = 1'b0;
            next_count_valid = 1'b0;
            next_running = 1'b0;
            next_hold = 1'b0;
            next_msb_next = 1'b0;
        end else if (i_count_wr) begin
            unique case (byte_access_format)
                `RL_LSB: begin
                    next_count_holding_register = {8'h00, i_data};
                end
                `RL_MSB: begin
                    next_count_holding_register = {i_data, 8'h00};
                end
                default: begin
                    if (!msb_next) begin
                        next_count_holding_register[7:0] = i_data;
                    end else begin
                        next_count_holding_register[15:8] = i_data;
                    end
                    next_msb_next = ~msb_next;
                end
            endcase
            if (byte_access_format == `RL_WORD && !msb_next) begin
                // first byte: only mode 0 reacts, at once
                if (operating_mode_field == interval_counter_pkg::MODE0) begin
                    next_hold = 1'b1;
                    next_out = 1'b0;
                end
            end else begin
                next_pending = 1'b1;
                next_count_valid = 1'b1;
                next_hold = 1'b0;
                if (operating_mode_field == interval_counter_pkg::MODE0) begin
                    next_out = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            operating_mode_field <= interval_counter_pkg::MODE0;
            bcd <= 1'b0;
            byte_access_format <= `RL_LSB;
            count_holding_register <= `COUNT_RESET;
            ce <= `COUNT_RESET;
            out <= 1'b1;
            pending <= 1'b0;
            count_valid <= 1'b0;
            running <= 1'b0;
            hold <= 1'b0;
            msb_next <= 1'b0;
            trig <= 1'b0;
            odd <= 1'b0;
        end else begin
            operating_mode_field <= next_operating_mode_field;
            bcd <= next_bcd;
            byte_access_format <= next_byte_access_format;
            count_holding_register <= next_count_holding_register;
            ce <= next_ce;
            out <= next_out;
            pending <= next_pending;
            count_valid <= next_count_valid;
            running <= next_running;
            hold <= next_hold;
            msb_next <= next_msb_next;
            trig <= next_trig;
            odd <= next_odd;
        end
    end

    assign o_wave_output_pin = out;
    assign o_count_value = ce;
endmodule : interval_counter_modes

/* File: interval_counter_cfg.svh */
// constants for one interval counter channel
// assumes an 8-bit cpu write path and a 16-bit counting element
`ifndef INTERVAL_COUNTER_CFG_SVH
`define INTERVAL_COUNTER_CFG_SVH

`define CNT_W 16
`define DATA_W 8
`define BCD_DIGITS 4

// control word fields
`define CW_SEL_HI 7
`define CW_SEL_LO 6
`define CW_RL_HI 5
`define CW_RL_LO 4
`define CW_MODE_HI 3
`define CW_MODE_LO 1
`define CW_BCD_BIT 0

// byte access formats
`define RL_LATCH 2'h0
`define RL_LSB 2'h1
`define RL_MSB 2'h2
`define RL_WORD 2'h3

// reset values and fixed counting figures
`define COUNT_RESET 16'h0000
`define RELOAD_EVEN_MASK 16'hFFFE
`define COUNT_ONE 16'h0001
`define COUNT_TWO 16'h0002
`define STEP_ONE 2'h1
`define STEP_TWO 2'h2
`define BCD_BASE 5'h0A

`endif

/* File: interval_counter_pkg.sv */
// types shared by the interval counter channel
// assumes nothing outside itself
package interval_counter_pkg;

    typedef enum logic [5:0] {
        MODE0 = 6'h01,
        MODE1 = 6'h02,
        MODE2 = 6'h04,
        MODE3 = 6'h08,
        MODE4 = 6'h10,
        MODE5 = 6'h20
    } mode_t;

endpackage : interval_counter_pkg

/* File: pin_events_if.sv */
// conditioned pin events passed from the pin stage to the channel core
// assumes both ends run on i_clk
`timescale 1ns/1ps
interface pin_events_if;
    logic tick;
    logic gate;
    logic gate_rise;

    modport src (
        output tick,
        output gate,
        output gate_rise
    );
    modport dst (
        input tick,
        input gate,
        input gate_rise
    );
endinterface : pin_events_if

/* File: pin_conditioner.sv */
// synchronises the count clock and gate pins and finds their edges
// assumes both pins are asynchronous to i_clk and much slower than it
`timescale 1ns/1ps
module pin_conditioner (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // pins
    input wire logic i_count_clk_pin,
    input wire logic i_gate_trigger_pin,
    // events
    pin_events_if.src ev
);
    logic clk_meta;
    logic clk_sync;
    logic clk_prev;
    logic gate_meta;
    logic gate_sync;
    logic gate_prev;
    logic next_clk_meta;
    logic next_clk_sync;
    logic next_clk_prev;
    logic next_gate_meta;
    logic next_gate_sync;
    logic next_gate_prev;

    always_comb begin
        next_clk_meta = i_count_clk_pin;
        next_clk_sync = clk_meta;
        next_clk_prev = clk_sync;
        next_gate_meta = i_gate_trigger_pin;
        next_gate_sync = gate_meta;
        next_gate_prev = gate_sync;
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            clk_meta <= 1'b0;
            clk_sync <= 1'b0;
            clk_prev <= 1'b0;
            // gate flops idle high: a held-high gate is no rise
            gate_meta <= 1'b1;
            gate_sync <= 1'b1;
            gate_prev <= 1'b1;
        end else begin
            clk_meta <= next_clk_meta;
            clk_sync <= next_clk_sync;
            clk_prev <= next_clk_prev;
            gate_meta <= next_gate_meta;
            gate_sync <= next_gate_sync;
            gate_prev <= next_gate_prev;
        end
    end

    // falling count clock gives one tick per counting clock
    assign ev.tick = clk_prev & ~clk_sync;
    assign ev.gate = gate_sync;
    assign ev.gate_rise = gate_sync & ~gate_prev;
endmodule : pin_conditioner

/* File: cpu_model.sv */
// cpu side model writing control words and count bytes to the channel
// assumes the bench calls its tasks one at a time, off the clock edge
`timescale 1ns/1ps
`include "interval_counter_cfg.svh"
module cpu_model (
    // clock
    input wire logic i_clk,
    // write path to the channel
    output logic o_ctrl_wr,
    output logic o_count_wr,
    output logic [`DATA_W-1:0] o_data
);
    logic rate_mode;
    logic lsb_only;

    initial begin
        o_ctrl_wr = 1'b0;
        o_count_wr = 1'b0;
        o_data = 8'h00;
        rate_mode = 1'b0;
        lsb_only = 1'b1;
    end

    task automatic write_ctrl(input logic [7:0] b);
        @(posedge i_clk);
        o_ctrl_wr <= 1'b1;
        o_data <= b;
        rate_mode = b[2];
        lsb_only = b[5:4] == 2'h1;
        @(posedge i_clk);
        o_ctrl_wr <= 1'b0;
        // released bus never shows the last byte
        o_data <= ~b;
    endtask : write_ctrl

    task automatic write_count(input logic [7:0] b);
        logic [7:0] v;
        v = (rate_mode && lsb_only && b == 8'h01) ? 8'h02 : b;
        @(posedge i_clk);
        o_count_wr <= 1'b1;
        o_data <= v;
        @(posedge i_clk);
        o_count_wr <= 1'b0;
        o_data <= ~v;
    endtask : write_count
endmodule : cpu_model

/* File: interval_counter_modes_asserts.sv */
// port checker for one interval counter channel
// assumes pins are driven in step with i_clk by the bench
`timescale 1ns/1ps
`include "interval_counter_cfg.svh"
module interval_counter_modes_chk #(
    parameter logic [1:0] CHANNEL = 2'h0
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_ctrl_wr,
    input wire logic i_count_wr,
    input wire logic [`DATA_W-1:0] i_data,
    input wire logic i_count_clk_pin,
    input wire logic i_gate_trigger_pin,
    input wire logic o_wave_output_pin,
    input wire logic [`CNT_W-1:0] o_count_value
);
    logic [2:0] mode;
    logic [2:0] md;
    logic [1:0] fmt;
    logic msb_next;
    logic pin_q;
    logic [3:0] idle;
    logic take_cw;

    assign take_cw = i_ctrl_wr && i_data[7:6] == CHANNEL
        && i_data[5:4] != 2'h0;
    assign md = mode[1] ? {1'b0, mode[1:0]} : mode;

    always_ff @(posedge i_clk) begin
        pin_q <= i_count_clk_pin;
        if (!i_nrst) begin
            mode <= 3'h0;
            fmt <= 2'h1;
            msb_next <= 1'b0;
            idle <= 4'h0;
        end else begin
            if (take_cw) begin
                mode <= i_data[3:1];
                fmt <= i_data[5:4];
                msb_next <= 1'b0;
            end else if (i_count_wr && fmt == 2'h3) begin
                msb_next <= !msb_next;
            end
            if (i_ctrl_wr || i_count_wr || (pin_q && !i_count_clk_pin)) begin
                idle <= 4'h0;
            end else if (idle != 4'hF) begin
                idle <= idle + 4'h1;
            end
        end
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst);

    reset_level_a: assert property ($rose(i_nrst) |->
        o_wave_output_pin && o_count_value == `COUNT_RESET)
        else $error("bad level after reset");
    cw_clear_a: assert property (take_cw |=>
        o_count_value == `COUNT_RESET
        && o_wave_output_pin == ($past(i_data[3:1]) != 3'h0))
        else $error("control word did not clear");
    m0_rise_zero_a: assert property (
        md == 3'h0 && $rose(o_wave_output_pin) |-> o_count_value == 16'h0)
        else $error("mode 0 rose before zero");
    m0_first_byte_a: assert property (
        md == 3'h0 && fmt == 2'h3 && i_count_wr && !msb_next && !i_ctrl_wr
        |=> !o_wave_output_pin) else $error("first byte kept output");
    count_quiet_a: assert property (
        idle > 4'h6 |-> $stable(o_count_value))
        else $error("count moved without a tick");
    m0_out_quiet_a: assert property (
        md == 3'h0 && idle > 4'h6 |-> $stable(o_wave_output_pin))
        else $error("mode 0 output moved by gate");
    m2_low_one_a: assert property (
        md == 3'h2 && $fell(o_wave_output_pin) |-> o_count_value == 16'h1)
        else $error("rate pulse not at one");
    gate_force_a: assert property (
        (md == 3'h2 || md == 3'h3) && $fell(i_gate_trigger_pin)
        && !o_wave_output_pin |-> ##[1:5] o_wave_output_pin)
        else $error("low gate did not force high");
    strobe_zero_a: assert property (
        (md == 3'h4 || md == 3'h5) && $fell(o_wave_output_pin)
        |-> o_count_value == 16'h0) else $error("strobe not at zero");
    m1_end_zero_a: assert property (
        md == 3'h1 && $rose(o_wave_output_pin) |-> o_count_value == 16'h0)
        else $error("one-shot ended early");

    cover property (md == 3'h2 && $fell(o_wave_output_pin));
    cover property (take_cw);
    cover property (md == 3'h5 && $fell(o_wave_output_pin));
endmodule : interval_counter_modes_chk

bind interval_counter_modes interval_counter_modes_chk #(
    .CHANNEL(CHANNEL)
) i_interval_counter_modes_chk (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_ctrl_wr(i_ctrl_wr),
    .i_count_wr(i_count_wr),
    .i_data(i_data),
    .i_count_clk_pin(i_count_clk_pin),
    .i_gate_trigger_pin(i_gate_trigger_pin),
    .o_wave_output_pin(o_wave_output_pin),
    .o_count_value(o_count_value)
);

/* File: test_interval_counter_modes.sv */
// self-checking bench for one interval counter channel
// assumes the channel, its checker and the cpu model are compiled first
`timescale 1ns/1ps
`include "interval_counter_cfg.svh"
`define CHECK(a, e) begin tests_run++; if ((a) !== (e)) begin \
    mismatches++; $display("[ERR] %0t %h %h", $time, a, e); end end
module test_interval_counter_modes;
    logic i_clk;
    logic i_nrst;
    logic pin;
    logic gate;
    logic ctrl_wr;
    logic count_wr;
    logic [`DATA_W-1:0] data;
    logic out;
    logic [`CNT_W-1:0] cnt;
    int mismatches;
    int tests_run;
    int cycles;
    logic [10:0] s;

    cpu_model i_cpu_model (.i_clk(i_clk), .o_ctrl_wr(ctrl_wr),
        .o_count_wr(count_wr), .o_data(data));
    interval_counter_modes i_interval_counter_modes (.i_clk(i_clk),
        .i_nrst(i_nrst), .i_ctrl_wr(ctrl_wr), .i_count_wr(count_wr),
        .i_data(data), .i_count_clk_pin(pin), .i_gate_trigger_pin(gate),
        .o_wave_output_pin(out), .o_count_value(cnt));

    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end

    task automatic report_and_stop();
        if (mismatches == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop

    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 4000) begin
            mismatches++;
            report_and_stop();
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
        @(negedge i_clk);
    endtask : cyc
    task automatic wc(input logic [7:0] b);
        i_cpu_model.write_ctrl(b);
        cyc(1);
    endtask : wc
    task automatic wn(input logic [7:0] b);
        i_cpu_model.write_count(b);
        cyc(1);
    endtask : wn
    // n count clock pulses per call, phases well over two cycles
    task automatic tk(input int n);
        repeat (n) begin
            @(posedge i_clk);
            pin <= 1'b0;
            repeat (4) @(posedge i_clk);
            pin <= 1'b1;
            cyc(3);
        end
    endtask : tk
    task automatic gt(input logic v);
        @(posedge i_clk);
        gate <= v;
        cyc(5);
    endtask : gt
    task automatic rec();
        for (int i = 0; i < 11; i++) begin
            tk(1);
            s[i] = out;
            `CHECK(cnt[0], 1'b0)
        end
    endtask : rec

    task automatic t_mode0();
        wc(8'h52);
        `CHECK(out, 1'b1)
        wc(8'h00);
        `CHECK(out, 1'b1)
        wc(8'h30);
        `CHECK(out, 1'b0)
        wn(8'h03);
        `CHECK(out, 1'b0)
        wn(8'h00);
        tk(1);
        `CHECK(cnt, 16'h0003)
        tk(2);
        `CHECK(out, 1'b0)
        tk(1);
        `CHECK(out, 1'b1)
        wn(8'h07);
        `CHECK(out, 1'b0)
        tk(1);
        `CHECK(cnt, 16'h0000)
        wn(8'h00);
        tk(1);
        `CHECK(cnt, 16'h0007)
    endtask : t_mode0

    task automatic t_gate0();
        wc(8'h10);
        gt(1'b0);
        wn(8'h02);
        tk(1);
        `CHECK(cnt, 16'h0002)
        tk(2);
        `CHECK(cnt, 16'h0002)
        gt(1'b1);
        `CHECK(out, 1'b0)
        tk(2);
        `CHECK(out, 1'b1)
        wn(8'h00);
        tk(2);
        `CHECK(cnt, 16'hFFFF)
        wc(8'h11);
        wn(8'h10);
        tk(2);
        `CHECK(cnt, 16'h0009)
        wn(8'h00);
        tk(2);
        `CHECK(cnt, 16'h9999)
        wc(8'h20);
        wn(8'h01);
        tk(1);
        `CHECK(cnt, 16'h0100)
    endtask : t_gate0

    task automatic t_mode1();
        wc(8'h12);
        wn(8'h03);
        tk(2);
        `CHECK(out, 1'b1)
        gt(1'b0);
        gt(1'b1);
        tk(1);
        `CHECK(cnt, 16'h0003)
        `CHECK(out, 1'b0)
        wn(8'h05);
        gt(1'b0);
        tk(2);
        `CHECK(cnt, 16'h0001)
        tk(1);
        `CHECK(out, 1'b1)
        tk(2);
        `CHECK(out, 1'b1)
        gt(1'b1);
        tk(1);
        `CHECK(cnt, 16'h0005)
    endtask : t_mode1

    task automatic t_mode2();
        wc(8'h1C);
        `CHECK(out, 1'b1)
        wn(8'h03);
        tk(3);
        `CHECK(cnt, 16'h0001)
        `CHECK(out, 1'b0)
        tk(1);
        `CHECK(cnt, 16'h0003)
        `CHECK(out, 1'b1)
        tk(2);
        gt(1'b0);
        `CHECK(out, 1'b1)
        gt(1'b1);
        tk(1);
        `CHECK(cnt, 16'h0003)
        wn(8'h04);
        tk(1);
        `CHECK(cnt, 16'h0002)
        tk(2);
        `CHECK(cnt, 16'h0004)
    endtask : t_mode2

    task automatic t_mode3();
        int z;
        wc(8'h16);
        wn(8'h04);
        rec();
        for (int i = 1; i < 9; i++) begin
            `CHECK(s[i + 2], ~s[i])
        end
        wc(8'h16);
        wn(8'h05);
        rec();
        z = 0;
        for (int i = 1; i < 6; i++) begin
            z += (s[i] === 1'b0);
            `CHECK(s[i + 5], s[i])
        end
        `CHECK(z, 2)
        wn(8'h06);
        tk(1);
        `CHECK(cnt, 16'h0002)
        tk(2);
        `CHECK(cnt, 16'h0006)
        `CHECK(out, 1'b0)
        gt(1'b0);
        `CHECK(out, 1'b1)
        tk(1);
        `CHECK(cnt, 16'h0006)
        gt(1'b1);
        tk(1);
        `CHECK(cnt, 16'h0006)
    endtask : t_mode3

    task automatic t_strobe();
        wc(8'h18);
        wn(8'h02);
        tk(2);
        `CHECK(out, 1'b1)
        tk(1);
        `CHECK(out, 1'b0)
        tk(1);
        `CHECK(out, 1'b1)
        wc(8'h38);
        wn(8'h05);
        wn(8'h00);
        tk(2);
        wn(8'h09);
        tk(1);
        `CHECK(cnt, 16'h0003)
        wn(8'h00);
        tk(1);
        `CHECK(cnt, 16'h0009)
        wc(8'h1A);
        wn(8'h02);
        tk(2);
        `CHECK(cnt, 16'h0000)
        gt(1'b0);
        gt(1'b1);
        tk(1);
        `CHECK(cnt, 16'h0002)
        wn(8'h04);
        gt(1'b0);
        gt(1'b1);
        tk(1);
        `CHECK(cnt, 16'h0004)
        tk(4);
        `CHECK(out, 1'b0)
        tk(1);
        `CHECK(out, 1'b1)
    endtask : t_strobe

    initial begin
        i_nrst = 1'b0;
        pin = 1'b1;
        gate = 1'b1;
        mismatches = 0;
        tests_run = 0;
        cycles = 0;
        s = 11'h000;
        repeat (16) @(posedge i_clk);
        i_nrst <= 1'b1;
        cyc(4);
        `CHECK(out, 1'b1)
        `CHECK(cnt, 16'h0000)
        t_mode0();
        t_gate0();
        t_mode1();
        t_mode2();
        t_mode3();
        t_strobe();
        report_and_stop();
    end
endmodule : test_interval_counter_modes
